/* File: core/pgc_pkg.sv */
/*
 * Package for the port pin configuration block: sub-register addresses,
 * host-port selectors, reset values, pin positions and the packed state
 * and carrier structs.
 * Assumes a single 100 MHz system clock and an asynchronous active-low reset.
 */
package pgc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NPORT = 3;
    localparam int WIDTH = 8;
    localparam int NPIN  = NPORT * WIDTH;

    // ------------------------------------------------------------------
    // Host port selectors (which register the access goes to)
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_ADDR = 2'h0;   // Port address register
    localparam logic [1:0] SEL_CTRL = 2'h1;   // Port control register
    localparam logic [1:0] SEL_IN   = 2'h2;   // Input data, read only
    localparam logic [1:0] SEL_OUT  = 2'h3;   // Output data

    // ------------------------------------------------------------------
    // Sub-register addresses held in the port address register
    // ------------------------------------------------------------------
    localparam logic [7:0] SUB_DIR    = 8'h01;
    localparam logic [7:0] SUB_ALT_EN = 8'h02;
    localparam logic [7:0] SUB_SMR    = 8'h05;
    localparam logic [7:0] SUB_PULLUP = 8'h06;
    localparam logic [7:0] SUB_SET_ONE = 8'h07;
    localparam logic [7:0] SUB_SET_TWO = 8'h08;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ADDR   = 8'h00;
    localparam logic [7:0] RST_DIR    = 8'hFF;  // 1 = input
    localparam logic [7:0] RST_ALT_EN = 8'h00;
    localparam logic [7:0] RST_OUT    = 8'h00;
    localparam logic [7:0] RST_SMR    = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_SET_ONE = 8'h00;
    localparam logic [7:0] RST_SET_TWO = 8'h00;

    // ------------------------------------------------------------------
    // Pin positions
    // ------------------------------------------------------------------
    localparam int PORT_A      = 0;
    localparam int PORT_B      = 1;
    localparam int XTAL_PIN0   = 0;   // Crystal pin zero, port A
    localparam int XTAL_PIN1   = 1;   // Crystal pin one, port A
    localparam int PB_CLK_BIT  = 3;   // Port B bit three
    localparam int ANA_BITS    = 6;   // Port B bits 0..5 analog

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] port;
        logic [1:0] sel;
        logic [7:0] wdata;
    } pgc_req_s;

    typedef struct packed {
        logic dir;
        logic out;
        logic alt;
        logic pu;
        logic smr;
        logic xtal;
    } pgc_pincfg_s;

    typedef struct packed {
        logic pin_o;
        logic oe;
        logic pu;
        logic in_bit;
        logic prev;
        logic wake;
    } pgc_cell_s;

    typedef struct packed {
        logic [NPORT-1:0][7:0] addr;
        logic [NPORT-1:0][7:0] dir;
        logic [NPORT-1:0][7:0] alt;
        logic [NPORT-1:0][7:0] out;
        logic [NPORT-1:0][7:0] smr;
        logic [NPORT-1:0][7:0] pu;
        logic [NPORT-1:0][7:0] set_one;
        logic [NPORT-1:0][7:0] set_two;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic [ANA_BITS-1:0]   ana;
        logic                  clk_sel;
        logic                  recovery;
    } pgc_state_s;

endpackage

/* File: core/pgc_pin_cell.sv */
/*
 * One port pin: output driver and enable, weak pull-up control, input
 * capture and stop-mode transition detection.
 * Assumes the pin input is synchronous to clock.
 */
`timescale 1ns/1ps
module pgc_pin_cell
(
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire pgc_pkg::pgc_pincfg_s cfg,
    input  wire logic                stop_mode,
    input  wire logic                pin_i,
    output logic                     pin_o,
    output logic                     pin_oe,
    output logic                     pull_en,
    output logic                     in_bit,
    output logic                     wake
);

    pgc_pkg::pgc_cell_s s_reg;
    pgc_pkg::pgc_cell_s s_next;

    // Next pin state
    always_comb
    begin
        s_next        = s_reg;
        s_next.pin_o  = cfg.out;
        s_next.oe     = ~cfg.dir & ~cfg.alt & ~cfg.xtal;
        s_next.pu     = cfg.pu & ~cfg.xtal;
        s_next.in_bit = cfg.xtal ? 1'b0 : pin_i;
        s_next.prev   = pin_i;
        s_next.wake   = stop_mode & cfg.smr & (pin_i ^ s_reg.prev);
    end

    // State register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops
    assign pin_o   = s_reg.pin_o;
    assign pin_oe  = s_reg.oe;
    assign pull_en = s_reg.pu;
    assign in_bit  = s_reg.in_bit;
    assign wake    = s_reg.wake;

endmodule

/* File: core/pgc_port_config.sv */
/*
 * Port pin configuration for three 8-bit ports: address and control
 * registers giving indirect access to per-pin sub-registers, crystal
 * override of port A, port B alternate-function decode and stop-mode
 * recovery detection.
 * Assumes host requests are synchronous single-cycle strobes and the
 * crystal enable and stop mode levels come from the clock controller.
 */
`timescale 1ns/1ps
module pgc_port_config
#(
    parameter bit EIGHT_PIN = 1'b0   // Clock input on crystal pin one
)
(
    input  wire logic                          clock,
    input  wire logic                          resetn,
    input  wire pgc_pkg::pgc_req_s             req,
    output logic [7:0]                         rdata,
    output logic                               rvalid,
    input  wire logic                          xtal_enable,
    input  wire logic                          stop_mode,
    input  wire logic [pgc_pkg::NPIN-1:0]      pin_i,
    output logic [pgc_pkg::NPIN-1:0]           pin_o,
    output logic [pgc_pkg::NPIN-1:0]           pin_oe,
    output logic [pgc_pkg::NPIN-1:0]           pull_en,
    output logic [pgc_pkg::ANA_BITS-1:0]       analog_sel,
    output logic                               external_clock_input_sel,
    output logic                               stop_recovery
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Registered state, per-pin configuration and cell returns
    pgc_pkg::pgc_state_s         s_reg;
    pgc_pkg::pgc_state_s         s_next;
    pgc_pkg::pgc_pincfg_s        cfg [pgc_pkg::NPIN];
    logic [pgc_pkg::NPIN-1:0]    in_bits;
    logic [pgc_pkg::NPIN-1:0]    wakes;
    logic [1:0]                  p;
    logic                        port_ok;

    // Port 3 is not built: its writes drop and its reads give zero
    assign p       = req.port;
    assign port_ok = (int'(req.port) < pgc_pkg::NPORT);

    // ------------------------------------------------------------------
    // Per-pin configuration fan-out
    // ------------------------------------------------------------------
    // Pins run port-major: pin 8*port+bit
    genvar gi;
    generate
        for (gi = 0; gi < pgc_pkg::NPIN; gi++)
        begin : g_pin
            // Port, bit and crystal-pin flag of this pin
            localparam int PT = gi / pgc_pkg::WIDTH;
            localparam int BT = gi % pgc_pkg::WIDTH;
            localparam bit XP = (PT == pgc_pkg::PORT_A)
                                && ((BT == pgc_pkg::XTAL_PIN0)
                                || (BT == pgc_pkg::XTAL_PIN1));

            always_comb
            begin
                cfg[gi].dir  = s_reg.dir[PT][BT];
                cfg[gi].out  = s_reg.out[PT][BT];
                cfg[gi].alt  = s_reg.alt[PT][BT];
                cfg[gi].pu   = s_reg.pu[PT][BT];
                cfg[gi].smr  = s_reg.smr[PT][BT];
                cfg[gi].xtal = XP & xtal_enable;
            end

            // One cell per pin, its outputs straight from flops
            pgc_pin_cell u_cell
            (
                .clock     (clock),
                .resetn    (resetn),
                .cfg       (cfg[gi]),
                .stop_mode (stop_mode),
                .pin_i     (pin_i[gi]),
                .pin_o     (pin_o[gi]),
                .pin_oe    (pin_oe[gi]),
                .pull_en   (pull_en[gi]),
                .in_bit    (in_bits[gi]),
                .wake      (wakes[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register access and decode
    // ------------------------------------------------------------------

    // Next-state: writes, read mux, function decode
    always_comb
    begin
        s_next        = s_reg;
        s_next.rvalid = req.rd;
        // Read data is zero unless a read is taken
        s_next.rdata  = 8'h00;

        // Host writes
        if (req.wr && port_ok)
        begin
            case (req.sel)
                pgc_pkg::SEL_ADDR: s_next.addr[p] = req.wdata;
                pgc_pkg::SEL_OUT:  s_next.out[p]  = req.wdata;
                pgc_pkg::SEL_CTRL:
                begin
                    case (s_reg.addr[p])
                        pgc_pkg::SUB_DIR:    s_next.dir[p]  = req.wdata;
                        pgc_pkg::SUB_ALT_EN: s_next.alt[p]  = req.wdata;
                        pgc_pkg::SUB_SMR:    s_next.smr[p]  = req.wdata;
                        pgc_pkg::SUB_PULLUP: s_next.pu[p]   = req.wdata;
                        pgc_pkg::SUB_SET_ONE: s_next.set_one[p] = req.wdata;
                        pgc_pkg::SUB_SET_TWO: s_next.set_two[p] = req.wdata;
                        default:             s_next.rdata   = s_next.rdata;
                    endcase
                end
                default: s_next.rdata = s_next.rdata;  // Input port is read only
            endcase
        end

        // Host reads, from pre-write state
        if (req.rd && port_ok)
        begin
            case (req.sel)
                pgc_pkg::SEL_ADDR: s_next.rdata = s_reg.addr[p];
                pgc_pkg::SEL_OUT:  s_next.rdata = s_reg.out[p];
                pgc_pkg::SEL_IN:   s_next.rdata = in_bits[p*pgc_pkg::WIDTH +: pgc_pkg::WIDTH];
                pgc_pkg::SEL_CTRL:
                begin
                    case (s_reg.addr[p])
                        pgc_pkg::SUB_DIR:    s_next.rdata = s_reg.dir[p];
                        pgc_pkg::SUB_ALT_EN: s_next.rdata = s_reg.alt[p];
                        pgc_pkg::SUB_SMR:    s_next.rdata = s_reg.smr[p];
                        pgc_pkg::SUB_PULLUP: s_next.rdata = s_reg.pu[p];
                        pgc_pkg::SUB_SET_ONE: s_next.rdata = s_reg.set_one[p];
                        pgc_pkg::SUB_SET_TWO: s_next.rdata = s_reg.set_two[p];
                        default:             s_next.rdata = 8'h00;
                    endcase
                end
                default: s_next.rdata = 8'h00;
            endcase
        end

        s_next.ana = s_reg.alt[pgc_pkg::PORT_B][pgc_pkg::ANA_BITS-1:0]
                   & s_reg.set_one[pgc_pkg::PORT_B][pgc_pkg::ANA_BITS-1:0];

        if (EIGHT_PIN)
        begin
            s_next.clk_sel = s_reg.alt[pgc_pkg::PORT_A][pgc_pkg::XTAL_PIN1] & ~xtal_enable;
        end
        else
        begin
            s_next.clk_sel = s_reg.alt[pgc_pkg::PORT_B][pgc_pkg::PB_CLK_BIT]
                           & ~s_reg.set_one[pgc_pkg::PORT_B][pgc_pkg::PB_CLK_BIT];
        end

        s_next.recovery = |wakes;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg          <= '0;
            s_reg.addr     <= {pgc_pkg::NPORT{pgc_pkg::RST_ADDR}};
            s_reg.dir      <= {pgc_pkg::NPORT{pgc_pkg::RST_DIR}};
            s_reg.alt      <= {pgc_pkg::NPORT{pgc_pkg::RST_ALT_EN}};
            s_reg.out      <= {pgc_pkg::NPORT{pgc_pkg::RST_OUT}};
            s_reg.smr      <= {pgc_pkg::NPORT{pgc_pkg::RST_SMR}};
            s_reg.pu       <= {pgc_pkg::NPORT{pgc_pkg::RST_PULLUP}};
            s_reg.set_one  <= {pgc_pkg::NPORT{pgc_pkg::RST_SET_ONE}};
            s_reg.set_two  <= {pgc_pkg::NPORT{pgc_pkg::RST_SET_TWO}};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Register-driven outputs
    assign rdata                    = s_reg.rdata;
    assign rvalid                   = s_reg.rvalid;
    assign analog_sel               = s_reg.ana;
    assign external_clock_input_sel = s_reg.clk_sel;
    assign stop_recovery            = s_reg.recovery;

endmodule

/* File: sim/pgc_port_config_properties.sv */
/*
 * Port-level checker for the port configuration block.
 * Assumes it is bound to every pgc_port_config instance.
 */
`timescale 1ns/1ps
module pgc_port_config_properties
#(
    parameter bit EIGHT_PIN = 1'b0
)
(
    input wire logic                           clock,
    input wire logic                           resetn,
    input wire pgc_pkg::pgc_req_s              req,
    input wire logic [7:0]                     rdata,
    input wire logic                           rvalid,
    input wire logic                           xtal_enable,
    input wire logic                           stop_mode,
    input wire logic [pgc_pkg::NPIN-1:0]       pin_i,
    input wire logic [pgc_pkg::NPIN-1:0]       pin_o,
    input wire logic [pgc_pkg::NPIN-1:0]       pin_oe,
    input wire logic [pgc_pkg::NPIN-1:0]       pull_en,
    input wire logic [pgc_pkg::ANA_BITS-1:0]   analog_sel,
    input wire logic                           external_clock_input_sel,
    input wire logic                           stop_recovery
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Reset, read port, crystal, decode and wake relations
    AST_RESET_DEFAULTS: assert property ($rose(resetn) |->
        pin_oe == '0 && pull_en == '0 && analog_sel == '0) else $error("Outputs busy after reset");
    AST_RVALID_AFTER_READ: assert property (
        req.rd && req.port != 2'h3 |=> rvalid) else $error("Read not answered");
    AST_RVALID_ONLY_READ: assert property (!req.rd |=> !rvalid)
        else $error("Answer without read");
    AST_RDATA_QUIET: assert property (!rvalid |-> rdata == 8'h00)
        else $error("Read data outside answer");
    AST_PORT3_READS_ZERO: assert property (
        req.rd && req.port == 2'h3 |=> rdata == 8'h00) else $error("Port 3 read not zero");
    AST_XTAL_OVERRIDE: assert property (xtal_enable [*2] |->
        pin_oe[1:0] == 2'h0 && pull_en[1:0] == 2'h0) else $error("Crystal pins not released");
    AST_CLOCK_OR_ANALOG: assert property (
        !EIGHT_PIN && external_clock_input_sel |-> !analog_sel[3]) else $error("Bit 3 double use");
    AST_WAKE_NEEDS_STOP: assert property (stop_recovery |-> $past(stop_mode, 2))
        else $error("Wake outside stop");
    AST_NO_WAKE_RUNNING: assert property ((!stop_mode) [*3] |-> !stop_recovery)
        else $error("Wake while running");
endmodule

bind pgc_port_config pgc_port_config_properties #(.EIGHT_PIN(EIGHT_PIN)) u_props (
    .clock(clock), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
    .xtal_enable(xtal_enable), .stop_mode(stop_mode), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .pull_en(pull_en), .analog_sel(analog_sel),
    .external_clock_input_sel(external_clock_input_sel), .stop_recovery(stop_recovery));

/* File: sim/pgc_pin_world.sv */
/*
 * Circuitry on the port pins: bench drivers, pull-ups, floating lines.
 * Assumes pin outputs and enables come from the configuration block.
 */
`timescale 1ns/1ps
module pgc_pin_world
(
    input  wire logic [23:0] pin_o,
    input  wire logic [23:0] pin_oe,
    input  wire logic [23:0] pull_en,
    input  wire logic [23:0] ext_en,
    input  wire logic [23:0] ext_val,
    input  wire logic        clock,
    output logic [23:0]      pin_i
);
    logic [23:0] float_reg = 24'h55_5555;

    // Undriven unpulled lines wander every cycle
    always_ff @(posedge clock)
        float_reg <= ~float_reg;

    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & pull_en) | (~pin_oe & ~ext_en & ~pull_en & float_reg);
endmodule

/* File: sim/tb.sv */
/*
 * Self-checking bench for the port configuration block.
 * Assumes the checker is bound and the pin model stands on the pins.
 */
`timescale 1ns/1ps
module tb;
    logic clock, resetn, xtal_enable, stop_mode, stop_recovery, rvalid, clk_in_sel;
    pgc_pkg::pgc_req_s req;
    logic [7:0]  rdata;
    logic [5:0]  analog_sel;
    logic [23:0] pin_i, pin_o, pin_oe, pull_en, ext_en, ext_val;
    int          bad_count, compares, n;

    pgc_port_config dut (.clock(clock), .resetn(resetn), .req(req), .rdata(rdata),
        .rvalid(rvalid), .xtal_enable(xtal_enable), .stop_mode(stop_mode), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en), .analog_sel(analog_sel),
        .external_clock_input_sel(clk_in_sel), .stop_recovery(stop_recovery));
    pgc_pin_world world (.pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en), .ext_en(ext_en),
        .ext_val(ext_val), .clock(clock), .pin_i(pin_i));

    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [1:0] p, input logic [1:0] s, input logic [7:0] d);
        @(posedge clock);
        #1 req = '{wr: w, rd: ~w, port: p, sel: s, wdata: d};
        @(posedge clock);
        #1 req = '0;
    endtask

    task automatic sub_wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, p, pgc_pkg::SEL_ADDR, a);
        acc(1'b1, p, pgc_pkg::SEL_CTRL, d);
    endtask

    task automatic dir_rd(input logic [1:0] p, input logic [1:0] s, input logic [7:0] e,
                          input string name);
        acc(1'b0, p, s, 8'h00);
        check({name, " valid"}, 24'h00_0001, 24'(rvalid));
        check(name, 24'(e), 24'(rdata));
    endtask

    task automatic sub_rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e,
                          input string name);
        acc(1'b1, p, pgc_pkg::SEL_ADDR, a);
        dir_rd(p, pgc_pkg::SEL_CTRL, e, name);
    endtask

    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic count_wake();
        n = 0;
        repeat (6)
        begin
            @(posedge clock);
            #1 if (stop_recovery === 1'b1) n++;
        end
    endtask

    task automatic t_reset();
        check("reset oe", 24'h00_0000, pin_oe);
        check("reset out", 24'h00_0000, pin_o);
        check("reset pull", 24'h00_0000, pull_en);
        check("reset alt", 24'h00_0000, 24'({analog_sel, clk_in_sel}));
        check("reset wake", 24'h00_0000, 24'(stop_recovery));
        sub_rd(2'h0, pgc_pkg::SUB_PULLUP, 8'h00, "pull A");
        sub_rd(2'h1, pgc_pkg::SUB_PULLUP, 8'h00, "pull B reset");
        sub_rd(2'h1, pgc_pkg::SUB_DIR, pgc_pkg::RST_DIR, "dir B");
        sub_rd(2'h1, pgc_pkg::SUB_ALT_EN, 8'h00, "alt en B reset");
    endtask

    task automatic t_pullup();
        sub_wr(2'h1, pgc_pkg::SUB_PULLUP, 8'hA5);
        sub_rd(2'h1, pgc_pkg::SUB_PULLUP, 8'hA5, "pull B");
        sub_rd(2'h1, 8'h09, 8'h00, "unmapped");
        settle();
        check("pull pins", 24'h00_A500, pull_en);
    endtask

    task automatic t_alt();
        sub_wr(2'h1, pgc_pkg::SUB_SET_ONE, 8'h21);
        sub_rd(2'h1, pgc_pkg::SUB_SET_ONE, 8'h21, "set one");
        settle();
        check("no enable", 24'h00_0000, 24'({analog_sel, clk_in_sel}));
        sub_wr(2'h1, pgc_pkg::SUB_ALT_EN, 8'h29);
        sub_rd(2'h1, pgc_pkg::SUB_ALT_EN, 8'h29, "alt en");
        settle();
        check("clock in", 24'h00_0043, 24'({analog_sel, clk_in_sel}));
        sub_wr(2'h1, pgc_pkg::SUB_SET_TWO, 8'hFF);
        settle();
        check("set two", 24'h00_0043, 24'({analog_sel, clk_in_sel}));
        sub_wr(2'h1, pgc_pkg::SUB_SET_ONE, 8'h08);
        settle();
        check("analog b3", 24'h00_0010, 24'({analog_sel, clk_in_sel}));
    endtask

    task automatic t_xtal();
        sub_wr(2'h0, pgc_pkg::SUB_PULLUP, 8'h03);
        sub_wr(2'h0, pgc_pkg::SUB_DIR, 8'h00);
        settle();
        check("drive A", 24'h00_00FF, pin_oe);
        xtal_enable = 1'b1;
        settle();
        check("xtal oe", 24'h00_00FC, pin_oe);
        check("xtal pull", 24'h00_A500, pull_en);
        xtal_enable = 1'b0;
        settle();
        check("xtal off", 24'h00_A503, pull_en);
    endtask

    task automatic t_data();
        acc(1'b1, 2'h0, pgc_pkg::SEL_OUT, 8'h5A);
        settle();
        check("pin out", 24'h00_005A, pin_o);
        dir_rd(2'h0, pgc_pkg::SEL_OUT, 8'h5A, "out A");
        dir_rd(2'h0, pgc_pkg::SEL_IN, 8'h5A, "in A");
        dir_rd(2'h0, pgc_pkg::SEL_ADDR, pgc_pkg::SUB_DIR, "addr A");
        dir_rd(2'h0, pgc_pkg::SEL_CTRL, 8'h00, "dir A");
        acc(1'b1, 2'h3, pgc_pkg::SEL_OUT, 8'hFF);
        dir_rd(2'h3, pgc_pkg::SEL_ADDR, 8'h00, "port 3");
        settle();
        check("port 3 drop", 24'h00_005A, pin_o);
    endtask

    task automatic t_stop();
        sub_wr(2'h2, pgc_pkg::SUB_SMR, 8'h04);
        sub_rd(2'h2, pgc_pkg::SUB_SMR, 8'h04, "smr C");
        stop_mode = 1'b1;
        settle();
        ext_val[18] = 1'b1;
        count_wake();
        check("wake", 24'h00_0001, 24'(n));
        stop_mode = 1'b0;
        settle();
        ext_val[18] = 1'b0;
        count_wake();
        check("wake running", 24'h00_0000, 24'(n));
        stop_mode = 1'b1;
        sub_wr(2'h2, pgc_pkg::SUB_SMR, 8'h00);
        settle();
        ext_val[18] = 1'b1;
        count_wake();
        check("wake masked", 24'h00_0000, 24'(n));
    endtask

    task automatic t_midreset();
        stop_mode = 1'b0;
        resetn = 1'b0;
        repeat (4) @(posedge clock);
        #1 resetn = 1'b1;
        t_reset();
    endtask

    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #50000;
        bad_count++;
        $display("Error watchdog expected done seen hang");
        give_verdict();
    end

    // Main sequence
    initial
    begin
        resetn = 1'b0;
        req = '0;
        xtal_enable = 1'b0;
        stop_mode = 1'b0;
        ext_en = 24'h04_0000;
        ext_val = 24'h00_0000;
        bad_count = 0;
        compares = 0;
        repeat (16) @(posedge clock);
        #1 resetn = 1'b1;
        t_reset();
        t_pullup();
        t_alt();
        t_xtal();
        t_data();
        t_stop();
        t_midreset();
        give_verdict();
    end
endmodule
